// file: design/msx_data_mem.sv
// msx_data_mem: data memory with one registered read port and one write port
// assumes read address is presented one cycle before the data is used
module msx_data_mem (
   // clock
   input wire logic clk,
   // read port
   input wire logic [msx_pkg::MSX_MEM_AW-1:0] rd_addr,
   output logic [7:0] rd_data,
   // write port
   input wire msx_pkg::msx_mem_wr_t wr
);
   import msx_pkg::*;

   logic [7:0] mem [0:(1<<MSX_MEM_AW)-1];

   // write-through so a read of the word just written sees new data
   always_ff @(posedge clk) begin
      if (wr.we) begin
         mem[wr.addr] <= wr.data;
      end
      if (wr.we && wr.addr == rd_addr) begin
         rd_data <= wr.data;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule : msx_data_mem

// file: design/msx_exec.sv
// msx_exec: executes the zero-test skips, the two table reads and the three xor forms
// assumes the decoder holds an instruction until instr_ready and the fetch unit
// drops its prefetched word when flush pulses; rom_data must be valid by the edge
// that ends the rom_req cycle, so the program rom is read without a register
// Function
// - zero data byte discards prefetched instruction, two cycles; nonzero takes one
// - move-and-skip copies byte to working register, skips two cycles when zero
// - bit test skips with dummy cycle when selected bit is zero
// - current-page table read: low byte to memory, high byte to table high
// - last-page table read: same transfer using the last program page
// - xor of register and memory byte goes to register, zero flag only
// - xor of memory byte and register written back to memory, zero flag only
// - xor of register and immediate goes to register, zero flag only
module msx_exec (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // decoded instruction
   input wire msx_pkg::msx_instr_t instr,
   output logic instr_ready,
   // pipeline control
   output logic flush,
   output logic busy,
   // table pointer and program page from the core
   input wire logic [7:0] table_pointer,
   input wire logic [msx_pkg::MSX_PAGE_W-1:0] current_page,
   // program rom port
   output logic rom_req,
   output logic [msx_pkg::MSX_ROM_AW-1:0] rom_addr,
   input wire logic [msx_pkg::MSX_ROM_DW-1:0] rom_data,
   // core state
   output logic [7:0] working_register,
   output logic [7:0] table_high_byte,
   output logic zero_flag,
   // data memory access for the core and observers
   input wire logic [msx_pkg::MSX_MEM_AW-1:0] core_rd_addr,
   output logic [7:0] mem_rd_data,
   input wire msx_pkg::msx_mem_wr_t core_wr
);
   import msx_pkg::*;

   msx_state_t state_q, state_d;
   logic [7:0] acc_q;
   logic [7:0] tbh_q;
   logic zf_q;
   logic [MSX_MEM_AW-1:0] tbl_addr_q;
   logic [MSX_ROM_AW-1:0] rom_addr_q;
   logic rom_req_q;
   logic flush_q;
   // operand staging: instruction is latched on the same edge that registers its memory byte
   msx_instr_t stage_q;
   logic stage_v_q;
   logic [7:0] mem_byte;
   logic [7:0] xor_res;
   logic skip_take;
   logic [MSX_MEM_AW-1:0] mem_rd_addr;
   msx_mem_wr_t wr_d;
   msx_mem_wr_t mem_wr;

   // read the operand address of an accepted instruction, otherwise serve the core
   assign mem_rd_addr = (instr.valid && instr_ready) ? instr.addr : core_rd_addr;

   msx_data_mem u_mem (
      .clk(clk),
      .rd_addr(mem_rd_addr),
      .rd_data(mem_byte),
      .wr(mem_wr)
   );

   assign mem_rd_data = mem_byte;

   // new work only while idle and no staged operand is pending
   assign instr_ready = (state_q == MSX_ST_EXEC) && !stage_v_q;
   assign busy = (state_q != MSX_ST_EXEC) || stage_v_q;

   // latch the instruction while its memory operand is read
   always_ff @(posedge clk) begin
      if (rst) begin
         stage_q <= '0;
         stage_v_q <= 1'b0;
      end else begin
         stage_v_q <= instr.valid && instr_ready && instr.op != MSX_OP_NONE;
         if (instr.valid && instr_ready) begin
            stage_q <= instr;
         end
      end
   end

   // xor source is the immediate or the memory byte
   assign xor_res = acc_q ^ ((stage_q.op == MSX_OP_XOR_IMM) ? stage_q.imm : mem_byte);

   // skip decision from the staged operand
   always_comb begin
      skip_take = 1'b0;
      if (stage_v_q) begin
         case (stage_q.op)
            MSX_OP_SKIP_ZERO: skip_take = (mem_byte == 8'h00);
            MSX_OP_MOVE_SKIP_ZERO: skip_take = (mem_byte == 8'h00);
            MSX_OP_SKIP_BIT_ZERO: skip_take = !mem_byte[stage_q.bit_sel];
            default: skip_take = 1'b0;
         endcase
      end
   end

   // phase sequencing: a taken skip spends one dummy cycle, a table read waits for rom
   always_comb begin
      state_d = state_q;
      case (state_q)
         MSX_ST_EXEC: begin
            if (skip_take) begin
               state_d = MSX_ST_DUMMY;
            end else if (stage_v_q && (stage_q.op == MSX_OP_TABLE_CURRENT ||
                                       stage_q.op == MSX_OP_TABLE_LAST)) begin
               state_d = MSX_ST_TABLE;
            end
         end
         MSX_ST_TABLE: state_d = MSX_ST_EXEC;
         MSX_ST_DUMMY: state_d = MSX_ST_EXEC;
         default: state_d = MSX_ST_EXEC;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= MSX_ST_EXEC;
      end else begin
         state_q <= state_d;
      end
   end

   // discard the prefetched word when a skip is taken
   always_ff @(posedge clk) begin
      if (rst) begin
         flush_q <= 1'b0;
      end else begin
         flush_q <= skip_take;
      end
   end
   assign flush = flush_q;

   // table read address: page from current or last page, low part from the pointer
   always_ff @(posedge clk) begin
      if (rst) begin
         rom_req_q <= 1'b0;
         rom_addr_q <= '0;
         tbl_addr_q <= '0;
      end else begin
         rom_req_q <= 1'b0;
         if (state_q == MSX_ST_EXEC && stage_v_q) begin
            tbl_addr_q <= stage_q.addr;
            if (stage_q.op == MSX_OP_TABLE_CURRENT) begin
               rom_req_q <= 1'b1;
               rom_addr_q <= {current_page, table_pointer};
            end else if (stage_q.op == MSX_OP_TABLE_LAST) begin
               rom_req_q <= 1'b1;
               rom_addr_q <= {MSX_LAST_PAGE, table_pointer};
            end
         end
      end
   end
   assign rom_req = rom_req_q;
   assign rom_addr = rom_addr_q;

   // table high byte takes the upper half of the fetched word
   always_ff @(posedge clk) begin
      if (rst) begin
         tbh_q <= MSX_TBH_RST;
      end else if (state_q == MSX_ST_TABLE) begin
         tbh_q <= rom_data[15:8];
      end
   end
   assign table_high_byte = tbh_q;

   // working register updates
   always_ff @(posedge clk) begin
      if (rst) begin
         acc_q <= MSX_ACC_RST;
      end else if (state_q == MSX_ST_EXEC && stage_v_q) begin
         case (stage_q.op)
            MSX_OP_MOVE_SKIP_ZERO: acc_q <= mem_byte;
            MSX_OP_XOR_ACC_MEM: acc_q <= xor_res;
            MSX_OP_XOR_IMM: acc_q <= xor_res;
            default: acc_q <= acc_q;
         endcase
      end
   end
   assign working_register = acc_q;

   // zero flag: only the xor forms touch it
   always_ff @(posedge clk) begin
      if (rst) begin
         zf_q <= MSX_ZF_RST;
      end else if (state_q == MSX_ST_EXEC && stage_v_q) begin
         case (stage_q.op)
            MSX_OP_XOR_ACC_MEM, MSX_OP_XOR_INTO_MEM, MSX_OP_XOR_IMM: begin
               zf_q <= (xor_res == 8'h00);
            end
            default: zf_q <= zf_q;
         endcase
      end
   end
   assign zero_flag = zf_q;

   // memory writes from this block take priority over the core port
   always_comb begin
      wr_d = '0;
      if (state_q == MSX_ST_TABLE) begin
         wr_d.we = 1'b1;
         wr_d.addr = tbl_addr_q;
         wr_d.data = rom_data[7:0];
      end else if (state_q == MSX_ST_EXEC && stage_v_q && stage_q.op == MSX_OP_XOR_INTO_MEM) begin
         wr_d.we = 1'b1;
         wr_d.addr = stage_q.addr;
         wr_d.data = xor_res;
      end
   end
   // core write only lands when the block is not writing in the same cycle
   // limitation: a colliding core write is dropped, the core must hold off while busy
   assign mem_wr = wr_d.we ? wr_d : core_wr;

endmodule : msx_exec

// file: design/msx_pkg.sv
// msx_pkg: shared types and constants for the skip / table-read / xor execution block
// assumes an 8-bit data path, a 16-bit program word and a 16-bit program address
package msx_pkg;

   localparam int MSX_DATA_W = 8;
   localparam int MSX_ROM_AW = 16;
   localparam int MSX_ROM_DW = 16;
   localparam int MSX_MEM_AW = 8;
   localparam int MSX_PAGE_W = 8; // page bits above the table pointer byte

   // reset values
   localparam logic [7:0] MSX_ACC_RST = 8'h00;
   localparam logic [7:0] MSX_TBH_RST = 8'h00;
   localparam logic MSX_ZF_RST = 1'b0;
   // page used by the last-page table read
   localparam logic [MSX_PAGE_W-1:0] MSX_LAST_PAGE = 8'hFF;
   // cycles spent by a taken skip and by an untaken one
   localparam int MSX_SKIP_CYCLES = 2;
   localparam int MSX_PLAIN_CYCLES = 1;

   // operation codes presented by the decoder
   typedef enum logic [3:0] {
      MSX_OP_NONE = 4'h0,
      MSX_OP_SKIP_ZERO = 4'h1,
      MSX_OP_MOVE_SKIP_ZERO = 4'h2,
      MSX_OP_SKIP_BIT_ZERO = 4'h3,
      MSX_OP_TABLE_CURRENT = 4'h4,
      MSX_OP_TABLE_LAST = 4'h5,
      MSX_OP_XOR_ACC_MEM = 4'h6,
      MSX_OP_XOR_INTO_MEM = 4'h7,
      MSX_OP_XOR_IMM = 4'h8
   } msx_op_t;

   // one decoded instruction
   typedef struct packed {
      logic valid;
      msx_op_t op;
      logic [MSX_MEM_AW-1:0] addr;
      logic [2:0] bit_sel;
      logic [7:0] imm;
   } msx_instr_t;

   // data-memory write request
   typedef struct packed {
      logic we;
      logic [MSX_MEM_AW-1:0] addr;
      logic [7:0] data;
   } msx_mem_wr_t;

   // execution phases
   typedef enum logic [1:0] {
      MSX_ST_EXEC = 2'b00,
      MSX_ST_TABLE = 2'b01,
      MSX_ST_DUMMY = 2'b10
   } msx_state_t;

endpackage : msx_pkg

// file: tb/msx_exec_monitor.sv
// msx_exec_monitor: port-level checks on the execution block
// assumes binding onto msx_exec, rising clk, rst synchronous active high
module msx_exec_monitor
   import msx_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // instruction side
   input wire msx_pkg::msx_instr_t instr,
   input wire logic instr_ready,
   input wire logic flush,
   input wire logic busy,
   // table side
   input wire logic [7:0] table_pointer,
   input wire logic [msx_pkg::MSX_PAGE_W-1:0] current_page,
   input wire logic rom_req,
   input wire logic [msx_pkg::MSX_ROM_AW-1:0] rom_addr,
   input wire logic [msx_pkg::MSX_ROM_DW-1:0] rom_data,
   // core state
   input wire logic [7:0] working_register,
   input wire logic [7:0] table_high_byte,
   input wire logic zero_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic take;
   // acceptance edge, as seen by the decoder
   assign take = instr.valid && instr_ready;
   chk_xor_imm: assert property (
      take && instr.op == MSX_OP_XOR_IMM |-> ##2 working_register == ($past(working_register, 2) ^
      $past(instr.imm, 2)) && zero_flag == (working_register == 8'h00)) else $error("xor imm result wrong");
   chk_move_skip: assert property (
      take && instr.op == MSX_OP_MOVE_SKIP_ZERO |-> ##2 flush == (working_register == 8'h00))
      else $error("move skip mismatch");
   chk_flush_cause: assert property (
      flush |-> $past(take, 2) && $past(instr.op, 2) inside {MSX_OP_SKIP_ZERO, MSX_OP_MOVE_SKIP_ZERO,
      MSX_OP_SKIP_BIT_ZERO}) else $error("flush without skip");
   chk_flush_once: assert property (flush |=> !flush && instr_ready)
      else $error("dummy cycle not single");
   chk_skip_busy: assert property (flush |-> busy && !instr_ready)
      else $error("dummy cycle not busy");
   chk_table_cur: assert property (
      take && instr.op == MSX_OP_TABLE_CURRENT |-> ##2 rom_req && rom_addr == {$past(current_page, 2),
      $past(table_pointer, 2)}) else $error("current page fetch wrong");
   chk_table_last: assert property (
      take && instr.op == MSX_OP_TABLE_LAST |-> ##2 rom_req && rom_addr == {MSX_LAST_PAGE,
      $past(table_pointer, 2)}) else $error("last page fetch wrong");
   chk_table_high: assert property (
      take && instr.op inside {MSX_OP_TABLE_CURRENT, MSX_OP_TABLE_LAST} |-> ##4
      table_high_byte == $past(rom_data[15:8])) else $error("table high byte wrong");
   chk_flags_kept: assert property (
      take && instr.op inside {[MSX_OP_SKIP_ZERO:MSX_OP_TABLE_LAST]} |=> $stable(zero_flag)[*4])
      else $error("flag moved");
   cover property (flush);
   cover property (take && instr.op == MSX_OP_TABLE_LAST);
   cover property (take && instr.op == MSX_OP_XOR_INTO_MEM);
endmodule : msx_exec_monitor

// file: tb/tb_top.sv
// tb_top: random self-checking bench for msx_exec
// assumes the bench stands in for decoder, rom and core memory port
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import msx_pkg::*;
   logic clk, rst, instr_ready, flush, busy, rom_req, zero_flag, zf, skip;
   logic [7:0] table_pointer, current_page, core_rd_addr, mem_rd_data, working_register, table_high_byte;
   logic [7:0] acc, tbh, m, a, imm, got;
   logic [15:0] rom_addr, rom_data, w;
   logic [2:0] b;
   msx_instr_t instr;
   msx_mem_wr_t core_wr;
   msx_op_t op;
   int n_mismatch, comparisons, cycles, seed, cyc;
   msx_exec msx_exec_inst (.clk, .rst, .instr, .instr_ready, .flush, .busy, .table_pointer, .current_page,
      .rom_req, .rom_addr, .rom_data, .working_register, .table_high_byte, .zero_flag, .core_rd_addr,
      .mem_rd_data, .core_wr);
   // program word pattern, distinct word per address; both bytes are equal on the last page
   function automatic logic [15:0] romf(input logic [15:0] ad);
      return {~ad[7:0], ad[15:8] ^ ad[7:0]};
   endfunction : romf
   task automatic summarize;
      $display("totals: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize
   task automatic wm(input logic [7:0] ad, input logic [7:0] d);
      @(negedge clk);
      core_wr = '{1'b1, ad, d};
      @(negedge clk);
      core_wr.we = 1'b0;
   endtask : wm
   // issue one instruction, count cycles until ready again
   task automatic run;
      @(negedge clk);
      instr = '{1'b1, op, a, b, imm};
      @(negedge clk);
      instr.valid = 1'b0;
      cyc = 1;
      while (instr_ready !== 1'b1 && cyc < 20) begin
         @(negedge clk);
         cyc++;
      end
   endtask : run
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // rom answers within half a cycle, before the edge that ends the rom_req cycle
   always @(negedge clk) rom_data <= romf(rom_addr);
   // hang guard, far above 64 tests of some 10 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         summarize();
      end
   end
   initial begin
      seed = 32'h3b0c;
      rst = 1'b1;
      instr = '0;
      core_wr = '0;
      core_rd_addr = 8'h00;
      table_pointer = 8'h00;
      current_page = 8'h00;
      {acc, tbh, zf} = '0;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 64; i++) begin
         op = msx_op_t'(4'(i % 8 + 1));
         {a, imm, b} = 19'($random(seed));
         // zero byte for both skip forms on half their runs, zero xor result on the two memory xor forms
         m = (i % 16 < 2) ? 8'h00 : (i % 16 > 12) ? acc : 8'($random(seed));
         if (i % 5 == 0) imm = acc; // zero result corner
         {table_pointer, current_page} = 16'($random(seed));
         wm(a, m);
         skip = 1'b0;
         case (op)
            MSX_OP_SKIP_ZERO: skip = (m == 8'h00);
            MSX_OP_MOVE_SKIP_ZERO: {acc, skip} = {m, m == 8'h00};
            MSX_OP_SKIP_BIT_ZERO: skip = !m[b];
            MSX_OP_TABLE_CURRENT, MSX_OP_TABLE_LAST: begin
               w = romf({op == MSX_OP_TABLE_LAST ? MSX_LAST_PAGE : current_page, table_pointer});
               {tbh, m} = w;
            end
            MSX_OP_XOR_ACC_MEM: {acc, zf} = {acc ^ m, (acc ^ m) == 8'h00};
            MSX_OP_XOR_INTO_MEM: {m, zf} = {acc ^ m, (acc ^ m) == 8'h00};
            default: {acc, zf} = {acc ^ imm, (acc ^ imm) == 8'h00};
         endcase
         run();
         `CHK("idle", 2'b10, {instr_ready, busy})
         if (op <= MSX_OP_SKIP_BIT_ZERO)
            `CHK("skip cycles", skip ? MSX_SKIP_CYCLES + 1 : MSX_PLAIN_CYCLES + 1, cyc)
         @(negedge clk);
         core_rd_addr = a;
         @(negedge clk);
         got = mem_rd_data;
         `CHK("memory", m, got)
         `CHK("acc", acc, working_register)
         `CHK("zero flag", zf, zero_flag)
         `CHK("table high", tbh, table_high_byte)
         $display("test %0d op %0d done", i, op);
      end
      summarize();
   end
endmodule : tb_top
bind msx_exec msx_exec_monitor msx_exec_monitor_inst (.clk, .rst, .instr, .instr_ready, .flush, .busy,
   .table_pointer, .current_page, .rom_req, .rom_addr, .rom_data, .working_register, .table_high_byte,
   .zero_flag);
